// *** dbio_pkg.sv ***
// Purpose: constants for the data-bus shared I/O ports
// Assumes: APB, 32-bit data, register index times four is the byte address
// Notes:   none
package dbio_pkg;
    localparam int          PORT_W        = 8;
    localparam int          ADDR_W        = 8;
    // register indices (byte address = index * 4)
    localparam logic [2:0]  IDX_LO_DATA   = 3'h0;
    localparam logic [2:0]  IDX_HI_DATA   = 3'h1;
    localparam logic [2:0]  IDX_LO_DIR    = 3'h2;
    localparam logic [2:0]  IDX_HI_DIR    = 3'h4;
    localparam logic [2:0]  IDX_HI_FUNC   = 3'h5;
    localparam logic [7:0]  RST_LATCH     = 8'h00;
    localparam logic [7:0]  RST_DIR       = 8'h00;
    localparam logic [7:0]  FUNC_ALL_BUS  = 8'hFF;
    localparam logic [7:0]  FUNC_ALL_PORT = 8'h00;
    // strap codes {upper, lower}
    localparam logic [1:0]  STRAP_BUS16   = 2'h1;
endpackage : dbio_pkg

// *** dbio_pin_if.sv ***
// Purpose: per-port control bundle between top and pin mux
// Assumes: one port of PORT_W pins
// Notes:   none
`timescale 1ns/1ps
interface dbio_pin_if #(parameter int W = 8);
    logic [W-1:0] latch;
    logic [W-1:0] dir;
    logic [W-1:0] bus_sel;
    logic         bus_drive;
    logic [W-1:0] bus_wdata;
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe_n;
    modport ctrl (output latch, dir, bus_sel, bus_drive, bus_wdata,
                  input pin_out, pin_oe_n);
    modport mux  (input latch, dir, bus_sel, bus_drive, bus_wdata,
                  output pin_out, pin_oe_n);
endinterface : dbio_pin_if

// *** dbio_pin_mux.sv ***
// Purpose: per-pin drive selection, port latch or data bus
// Assumes: output enable is active low
// Notes:   purely combinational
`timescale 1ns/1ps
module dbio_pin_mux #(
    parameter int W = 8
) (
    dbio_pin_if.mux p
);
    import dbio_pkg::*;
    for (genvar i = 0; i < W; i++) begin : g_pin
        always_comb begin
            if (p.bus_sel[i]) begin
                p.pin_out[i]  = p.bus_wdata[i];
                p.pin_oe_n[i] = ~p.bus_drive;
            end else begin
                p.pin_out[i]  = p.latch[i];
                p.pin_oe_n[i] = ~p.dir[i];
            end
        end
    end
endmodule : dbio_pin_mux

// *** dbio_top.sv ***
// Purpose: two 8-bit I/O ports shared with the external data bus
// Assumes: APB slave, one clock, straps steady at reset release
// Notes:   direction and function registers are write-only
//          read data is taken in the setup cycle, zero wait states
//          high function follows the straps once after reset
//          function and direction both set is kept an output
//
// Summary of operation
// - one direction bit per low pin, 1=out
// - reset clears low direction bits
// - external access uses low pins as D0-D7
// - low direction forced zero while bus
// - data reads return pins, latches reset zero
// - high function bits loaded from straps
// - high pin mode from function and direction
// - reset clears high latch and direction
`timescale 1ns/1ps
module dbio_top (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // apb
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [dbio_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // straps
    input  wire logic                      bus_mode_strap_upper,
    input  wire logic                      bus_mode_strap_lower,
    // external bus controller
    input  wire logic                      ext_access,
    input  wire logic                      ext_write,
    input  wire logic [15:0]               ext_wdata,
    output logic      [15:0]               ext_rdata,
    // low port pins
    input  wire logic [dbio_pkg::PORT_W-1:0] lo_pin_in,
    output logic      [dbio_pkg::PORT_W-1:0] lo_pin_out,
    output logic      [dbio_pkg::PORT_W-1:0] lo_pin_oe_n,
    // high port pins
    input  wire logic [dbio_pkg::PORT_W-1:0] hi_pin_in,
    output logic      [dbio_pkg::PORT_W-1:0] hi_pin_out,
    output logic      [dbio_pkg::PORT_W-1:0] hi_pin_oe_n
);
    import dbio_pkg::*;

    // ----------------------------------------------------------------
    // types and state
    // ----------------------------------------------------------------
    // pin operating mode, one-hot
    typedef enum logic [2:0] {
        MODE_IN  = 3'b001,
        MODE_OUT = 3'b010,
        MODE_BUS = 3'b100
    } dbio_mode_e;

    // start-up phase, one-hot
    typedef enum logic [1:0] {
        PH_STRAP = 2'b01,
        PH_RUN   = 2'b10
    } dbio_phase_e;

    typedef struct packed {
        logic [7:0]  lo_latch;   // low port output latch
        logic [7:0]  hi_latch;   // high port output latch
        logic [7:0]  lo_dir;     // low port direction, 1 = output
        logic [7:0]  hi_dir;     // high port direction
        logic [7:0]  hi_func;    // high port function, 1 = bus
        dbio_phase_e phase;      // straps pending or taken
        logic [31:0] rdata;      // read data held for the access phase
    } dbio_state_s;

    dbio_state_s s_q;
    dbio_state_s s_d;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic       acc;
    logic       setup;
    logic       wr;
    logic       rd_setup;
    logic [2:0] idx;
    logic       addr_ok;
    logic       sel_lo_data;
    logic       sel_hi_data;
    logic       sel_lo_dir;
    logic       sel_hi_dir;
    logic       sel_hi_func;
    logic       mapped;
    logic       byte_wr;
    logic       we_lo_data;
    logic       we_hi_data;
    logic       we_lo_dir;
    logic       we_hi_dir;
    logic       we_hi_func;

    assign acc      = psel & penable;
    assign setup    = psel & ~penable;
    assign wr       = acc & pwrite;
    assign rd_setup = setup & ~pwrite;
    assign idx      = paddr[4:2];
    assign addr_ok  = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0);

    // register selects
    assign sel_lo_data = addr_ok && (idx == IDX_LO_DATA);
    assign sel_hi_data = addr_ok && (idx == IDX_HI_DATA);
    assign sel_lo_dir  = addr_ok && (idx == IDX_LO_DIR);
    assign sel_hi_dir  = addr_ok && (idx == IDX_HI_DIR);
    assign sel_hi_func = addr_ok && (idx == IDX_HI_FUNC);
    assign mapped      = sel_lo_data | sel_hi_data | sel_lo_dir | sel_hi_dir | sel_hi_func;

    // low byte lane carries the register byte
    assign byte_wr    = wr & pstrb[0];
    assign we_lo_data = byte_wr & sel_lo_data;
    assign we_hi_data = byte_wr & sel_hi_data;
    assign we_lo_dir  = byte_wr & sel_lo_dir;
    assign we_hi_dir  = byte_wr & sel_hi_dir;
    assign we_hi_func = byte_wr & sel_hi_func;

    // ----------------------------------------------------------------
    // strap decode
    // ----------------------------------------------------------------
    logic [1:0] strap_code;
    logic [7:0] strap_func;

    assign strap_code = {bus_mode_strap_upper, bus_mode_strap_lower};
    // forbidden code 10 falls back to port
    assign strap_func = (strap_code == STRAP_BUS16) ? FUNC_ALL_BUS : FUNC_ALL_PORT;

    // ----------------------------------------------------------------
    // read data select
    // ----------------------------------------------------------------
    // direction and function are write-only and read as zero
    logic [7:0] rd_byte;

    always_comb begin
        case (idx)
            IDX_LO_DATA: rd_byte = lo_pin_in;
            IDX_HI_DATA: rd_byte = hi_pin_in;
            IDX_LO_DIR:  rd_byte = 8'h00;
            IDX_HI_DIR:  rd_byte = 8'h00;
            IDX_HI_FUNC: rd_byte = 8'h00;
            default:     rd_byte = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // straps taken on the first edge after release
        case (s_q.phase)
            PH_STRAP: begin
                s_d.phase   = PH_RUN;
                s_d.hi_func = strap_func;
            end
            PH_RUN: begin
                s_d.phase = PH_RUN;
            end
            default: begin
                s_d.phase = PH_STRAP;
            end
        endcase
        if (we_lo_data) begin
            s_d.lo_latch = pwdata[7:0];
        end
        if (we_hi_data) begin
            s_d.hi_latch = pwdata[7:0];
        end
        if (we_lo_dir) begin
            s_d.lo_dir = pwdata[7:0];
        end
        if (we_hi_dir) begin
            s_d.hi_dir = pwdata[7:0];
        end
        if (we_hi_func) begin
            s_d.hi_func = pwdata[7:0];
        end
        // bus use wins over a direction write in the same cycle
        if (ext_access) begin
            s_d.lo_dir = RST_DIR;
        end
        // taken in setup so the access phase already shows it
        if (rd_setup && mapped) begin
            s_d.rdata = {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q.lo_latch <= RST_LATCH;
            s_q.hi_latch <= RST_LATCH;
            s_q.lo_dir   <= RST_DIR;
            s_q.hi_dir   <= RST_DIR;
            s_q.hi_func  <= FUNC_ALL_PORT;
            s_q.phase    <= PH_STRAP;
            s_q.rdata    <= 32'h00000000;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // apb answer
    // ----------------------------------------------------------------
    // zero wait states; unmapped or misaligned gives an error
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = s_q.rdata;

    // ----------------------------------------------------------------
    // pin modes
    // ----------------------------------------------------------------
    dbio_mode_e        lo_mode [PORT_W];
    dbio_mode_e        hi_mode [PORT_W];
    logic [PORT_W-1:0] lo_bus;
    logic [PORT_W-1:0] lo_out;
    logic [PORT_W-1:0] hi_bus;
    logic [PORT_W-1:0] hi_out;

    for (genvar i = 0; i < PORT_W; i++) begin : g_mode
        // low pins: bus during any external access
        always_comb begin
            if (ext_access) begin
                lo_mode[i] = MODE_BUS;
            end else if (s_q.lo_dir[i]) begin
                lo_mode[i] = MODE_OUT;
            end else begin
                lo_mode[i] = MODE_IN;
            end
        end
        // high pins: function 1 with direction 0 is bus,
        // forbidden 1/1 is kept an output
        always_comb begin
            if (s_q.hi_func[i] && !s_q.hi_dir[i]) begin
                hi_mode[i] = MODE_BUS;
            end else if (s_q.hi_dir[i]) begin
                hi_mode[i] = MODE_OUT;
            end else begin
                hi_mode[i] = MODE_IN;
            end
        end
        // mode flattened into bits for the muxes
        assign lo_bus[i] = (lo_mode[i] == MODE_BUS);
        assign lo_out[i] = (lo_mode[i] == MODE_OUT);
        assign hi_bus[i] = (hi_mode[i] == MODE_BUS);
        assign hi_out[i] = (hi_mode[i] == MODE_OUT);
    end

    // ----------------------------------------------------------------
    // external bus
    // ----------------------------------------------------------------
    logic bus_wr;

    // bus pins drive only on external writes
    assign bus_wr    = ext_access & ext_write;
    // bus read data is the raw pin levels
    assign ext_rdata = {hi_pin_in, lo_pin_in};

    // ----------------------------------------------------------------
    // low port pins
    // ----------------------------------------------------------------
    dbio_pin_if #(.W(PORT_W)) lo_if ();

    assign lo_if.latch     = s_q.lo_latch;
    assign lo_if.dir       = lo_out;
    assign lo_if.bus_sel   = lo_bus;
    assign lo_if.bus_drive = bus_wr;
    assign lo_if.bus_wdata = ext_wdata[7:0];

    dbio_pin_mux #(.W(PORT_W)) u_lo_mux (.p(lo_if.mux));

    assign lo_pin_out  = lo_if.pin_out;
    assign lo_pin_oe_n = lo_if.pin_oe_n;

    // ----------------------------------------------------------------
    // high port pins
    // ----------------------------------------------------------------
    dbio_pin_if #(.W(PORT_W)) hi_if ();

    assign hi_if.latch     = s_q.hi_latch;
    assign hi_if.dir       = hi_out;
    assign hi_if.bus_sel   = hi_bus;
    assign hi_if.bus_drive = bus_wr;
    assign hi_if.bus_wdata = ext_wdata[15:8];

    dbio_pin_mux #(.W(PORT_W)) u_hi_mux (.p(hi_if.mux));

    assign hi_pin_out  = hi_if.pin_out;
    assign hi_pin_oe_n = hi_if.pin_oe_n;
endmodule : dbio_top

// *** dbio_ext_mem.sv ***
// Purpose: far-side devices on the shared data bus
// Assumes: no pull resistors on the bus lines
// Notes: released lines show a pattern that moves every cycle
`timescale 1ns/1ps
module dbio_ext_mem (
    input  wire logic        sys_clk,
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] oe_n,
    output logic      [15:0] pin_in
);
    logic [15:0] pat_q = 16'hA5C3;
    always_ff @(posedge sys_clk) pat_q <= ~{pat_q[14:0], pat_q[15]};
    assign pin_in = (pin_out & ~oe_n) | (pat_q & oe_n);
endmodule : dbio_ext_mem

// *** dbio_top_assertions.sv ***
// Purpose: port checks for dbio_top
// Assumes: zero-wait apb, registered read data
// Notes: bound below
`timescale 1ns/1ps
module dbio_top_assertions import dbio_pkg::*; (
    input wire logic sys_clk, rst, psel, penable, pwrite, ext_access, ext_write,
    input wire logic bus_mode_strap_upper, bus_mode_strap_lower,
    input wire logic [7:0] paddr, lo_pin_in, lo_pin_out, lo_pin_oe_n, hi_pin_oe_n,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    input wire logic [15:0] ext_wdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire wr = psel && penable && pwrite && pstrb[0];
    a_reset_in: assert property ($fell(rst) |-> ext_access || lo_pin_oe_n == 8'hFF)
        else $error("pin driven after reset");
    a_bus_dir: assert property (ext_access |-> lo_pin_oe_n == {8{!ext_write}})
        else $error("bus drive");
    a_bus_data: assert property (ext_access && ext_write |-> lo_pin_out == ext_wdata[7:0])
        else $error("bus data");
    a_dir_clear: assert property ($past(ext_access) && !ext_access && !$past(wr)
        |-> lo_pin_oe_n == 8'hFF) else $error("dir kept");
    a_dir_drive: assert property (wr && paddr == 8'h08
        |=> ext_access || lo_pin_oe_n == ~$past(pwdata[7:0])) else $error("dir");
    a_latch_out: assert property (wr && paddr == 8'h00
        |=> ext_access || lo_pin_out == $past(pwdata[7:0])) else $error("latch");
    a_pin_read: assert property (psel && penable && !pwrite && paddr == 8'h00
        |-> prdata == {24'h0, $past(lo_pin_in)}) else $error("read");
    a_strap_bus: assert property ($fell(rst)
        && {bus_mode_strap_upper, bus_mode_strap_lower} == STRAP_BUS16
        |=> hi_pin_oe_n == {8{!(ext_access && ext_write)}}) else $error("strap");
endmodule : dbio_top_assertions
bind dbio_top dbio_top_assertions u_chk (.sys_clk, .rst, .psel, .penable, .pwrite,
    .ext_access, .ext_write, .bus_mode_strap_upper, .bus_mode_strap_lower, .paddr,
    .lo_pin_in, .lo_pin_out, .lo_pin_oe_n, .hi_pin_oe_n, .pwdata, .prdata, .pstrb, .ext_wdata);

// *** test_data_bus_shared_io_ports.sv ***
// Purpose: self-checking bench for the shared data-bus ports
// Assumes: straps never 10
// Notes: pin levels come from dbio_ext_mem
`timescale 1ns/1ps
module test_data_bus_shared_io_ports;
    import dbio_pkg::*;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, up = 0, lw = 0;
    logic ea = 0, ew = 0, pready, pslverr, e;
    logic [7:0] paddr = 8'h00;
    logic [15:0] wd = 16'h0000, rdx, pin_s;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [1:0] st [3] = '{2'h1, 2'h0, 2'h3};
    wire [15:0] pin_in, pin_out, oe_n;
    int n_fail = 0, n_checks = 0, lat, dir, fn, r, b, x;
    dbio_top dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
        .prdata, .pready, .pslverr, .bus_mode_strap_upper(up), .bus_mode_strap_lower(lw),
        .ext_access(ea), .ext_write(ew), .ext_wdata(wd), .ext_rdata(rdx),
        .lo_pin_in(pin_in[7:0]), .lo_pin_out(pin_out[7:0]), .lo_pin_oe_n(oe_n[7:0]),
        .hi_pin_in(pin_in[15:8]), .hi_pin_out(pin_out[15:8]), .hi_pin_oe_n(oe_n[15:8]));
    dbio_ext_mem u_ext (.sys_clk, .pin_out, .oe_n, .pin_in);
    initial forever #5 sys_clk = ~sys_clk;
    initial begin #100000 n_fail++; end_of_test; end
    task end_of_test;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task chk(string nm, logic [31:0] s, logic [31:0] y);
        n_checks++;
        if (s !== y) begin n_fail++; $display("FAIL %s exp %h seen %h", nm, y, s); end
    endtask : chk
    task apb(logic w, logic [7:0] a, int d);
        @(posedge sys_clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge sys_clk) penable <= 1;
        pin_s = pin_in;
        do @(posedge sys_clk); while (pready !== 1'b1);
        e = pslverr;
        q = prdata;
        {psel, penable} <= 2'b00;
        if (w) case (a) 8'h00: lat[7:0] = d[7:0]; 8'h04: lat[15:8] = d[7:0];
            8'h08: dir[7:0] = d[7:0]; 8'h10: dir[15:8] = d[7:0]; 8'h14: fn = d[7:0]; endcase
    endtask : apb
    task pins;
        #1 b = ea ? {fn[7:0] & ~dir[15:8], 8'hFF} : 0;
        x = (b & {16{~ew}}) | (~b & ~dir & 'hFFFF);
        chk("oe_n", oe_n, x);
        chk("pin_out", pin_out & ~x[15:0], ((b & {16{ew}} & wd) | (~b & lat)) & ~x);
        chk("ext_rdata", rdx, pin_in);
    endtask : pins
    task do_rst(logic [1:0] s);
        @(posedge sys_clk) {rst, up, lw} <= {1'b1, s};
        repeat (16) @(posedge sys_clk);
        rst <= 0;
        lat = 0;
        dir = 0;
        fn = s == STRAP_BUS16 ? 'hFF : 0;
        @(posedge sys_clk) pins;
    endtask : do_rst
    initial begin
        r = $urandom(89636);
        foreach (st[k]) begin
            do_rst(st[k]);
            repeat (4) begin
                r = $urandom;
                apb(1, 8'h10, r[23:16] & ~r[7:0] & ~fn[7:0]);
                apb(1, 8'h14, r[7:0]);
                apb(1, 8'h08, r[15:8]);
                apb(1, 8'h00, r[31:24]);
                apb(1, 8'h04, $urandom);
                pins;
                for (int i = 0; i < 2; i++) begin
                    apb(0, i * 4, 0);
                    chk("pin_rd", q, pin_s[i*8+:8]);
                end
                apb(0, 8'h10, 0);
                chk("dir_rd", q, 0);
                apb(0, 8'h0C, 0);
                chk("slverr", e, 1);
                @(posedge sys_clk) {ea, ew, wd} <= {1'b1, r[8], r[31:16]};
                @(posedge sys_clk) pins;
                @(posedge sys_clk) ea <= 0;
                dir = dir & 'hFF00;
                @(posedge sys_clk) pins;
            end
        end
        end_of_test;
    end
endmodule : test_data_bus_shared_io_ports
